// file: include/aos_pkg.sv
// Operation
// - Removing the core supply puts the block into sleep; always-on logic keeps running.
// - In sleep, a change on any jack sense pin can raise an interrupt event.
// - Always-on control fields keep their values across sleep; sleep never resets them.
// - Always-on domain holds clamp, enable, event, mask, irq config and reset pull fields.
// - No register read or write is possible while asleep.
// - In sleep, non always-on inputs are ignored and outputs left undriven.
// - In sleep, drivers and bus keepers of non always-on pins are disabled.
// - In sleep, irq stays deasserted unless a jack sense input causes an event.
// - Irq asserted during sleep stays asserted until after wake-up.
// - Always-on pins: irq output, three jack sense inputs, active-low reset input.
// - Each enabled jack state follows its own jack sense pin.
// - Clamp status comes from the jack states through a mode-selected logic function.
// - Only one clamp is active at a time; clamp status reports that one only.
// - Jack states and clamp status feed the interrupt events, also in sleep.
// - Jack activity never wakes the block; only restoring the core supply does.
// - Registers below index 0x3000 use the 16-bit format.
package aos_pkg;
  localparam int unsigned REG_W = 16;
  localparam int unsigned EV_N  = 10;
  localparam int unsigned JD_N  = 3;
  // register indices; byte address is four times the index
  localparam logic [15:0] IDX_CLAMP  = 16'h02C6;
  localparam logic [15:0] IDX_ENA    = 16'h02D3;
  localparam logic [15:0] IDX_STAT   = 16'h1806;
  localparam logic [15:0] IDX_MASK   = 16'h1846;
  localparam logic [15:0] IDX_IRQCFG = 16'h1A80;
  localparam logic [15:0] IDX_PULLS  = 16'h1AD0;
  localparam logic [15:0] IDX_WIDE   = 16'h3000;
  // field positions
  localparam int unsigned CL_A_LSB  = 0;
  localparam int unsigned CL_A_OVD  = 4;
  localparam int unsigned CL_B_LSB  = 8;
  localparam int unsigned CL_B_OVD  = 11;
  localparam int unsigned JD_EN_LSB = 0;
  localparam int unsigned BIAS_EN   = 3;
  localparam int unsigned IRQ_MSK   = 0;
  localparam int unsigned IRQ_POLARITY   = 1;
  localparam int unsigned IRQ_OD    = 2;
  localparam int unsigned PULL_UP   = 0;
  localparam int unsigned PULL_DN   = 1;
  localparam int unsigned EV_JD1_R  = 0;
  localparam int unsigned EV_JD1_F  = 1;
  localparam int unsigned EV_JD2_R  = 2;
  localparam int unsigned EV_JD2_F  = 3;
  localparam int unsigned EV_CLA_R  = 4;
  localparam int unsigned EV_CLA_F  = 5;
  localparam int unsigned EV_JD3_R  = 6;
  localparam int unsigned EV_JD3_F  = 7;
  localparam int unsigned EV_CLB_R  = 8;
  localparam int unsigned EV_CLB_F  = 9;
  // writable bits and reset values
  localparam logic [15:0] WM_CLAMP  = 16'h0F1F;
  localparam logic [15:0] WM_ENA    = 16'h000F;
  localparam logic [15:0] WM_EVT    = 16'h03FF;
  localparam logic [15:0] WM_IRQCFG = 16'h0007;
  localparam logic [15:0] WM_PULLS  = 16'h0003;
  localparam logic [15:0] RST_CLAMP = 16'h0000;
  localparam logic [15:0] RST_ENA   = 16'h0000;
  localparam logic [15:0] RST_MASK  = 16'h03FF;
  localparam logic [15:0] RST_IRQC  = 16'h0000;
  localparam logic [15:0] RST_PULLS = 16'h0001;
  // clamp logic select codes
  localparam logic [3:0] CM_OFF   = 4'h0;
  localparam logic [3:0] CM_JD1   = 4'h1;
  localparam logic [3:0] CM_NJD1  = 4'h2;
  localparam logic [3:0] CM_JD2   = 4'h3;
  localparam logic [3:0] CM_NJD2  = 4'h4;
  localparam logic [3:0] CM_JD3   = 4'h5;
  localparam logic [3:0] CM_NJD3  = 4'h6;
  localparam logic [3:0] CM_AND12 = 4'h7;
  localparam logic [3:0] CM_OR12  = 4'h8;

  typedef enum logic {AOS_AWAKE, AOS_SLEEP} aos_pwr_type;

  typedef struct packed {
    logic [JD_N-1:0] jd_en;
    logic [3:0]      a_sel;
    logic            a_ovd;
    logic [2:0]      b_sel;
    logic            b_ovd;
  } aos_jcfg_type;

  typedef struct packed {
    logic [JD_N-1:0] jd;
    logic            clamp;
    logic [EV_N-1:0] evt;
  } aos_jstat_type;

  function automatic logic [15:0] aos_addr(input logic [15:0] idx);
    return {idx[13:0], 2'b00};
  endfunction : aos_addr
endpackage : aos_pkg

// file: rtl/aos_jack_track.sv
`timescale 1ns/1ps
module aos_jack_track (
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic [aos_pkg::JD_N-1:0] pins,
  input  wire aos_pkg::aos_jcfg_type   cfg,
  output aos_pkg::aos_jstat_type       st
);
  typedef struct packed {
    logic [aos_pkg::JD_N-1:0] jd;
    logic                     clamp;
  } aos_jt_type;

  aos_jt_type s_r;
  aos_jt_type s_nxt;
  logic       a_on;
  logic [aos_pkg::JD_N-1:0] rise;
  logic [aos_pkg::JD_N-1:0] fall;

  function automatic logic aos_clamp_fn(input logic [3:0] m, input logic [2:0] j);
    case (m)
      aos_pkg::CM_JD1:   return j[0];
      aos_pkg::CM_NJD1:  return ~j[0];
      aos_pkg::CM_JD2:   return j[1];
      aos_pkg::CM_NJD2:  return ~j[1];
      aos_pkg::CM_JD3:   return j[2];
      aos_pkg::CM_NJD3:  return ~j[2];
      aos_pkg::CM_AND12: return j[0] & j[1];
      aos_pkg::CM_OR12:  return j[0] | j[1];
      default:           return 1'b0;
    endcase
  endfunction : aos_clamp_fn

  always_comb begin
    s_nxt = s_r;
    s_nxt.jd = pins & cfg.jd_en;
    // shared logic: clamp a takes precedence whenever it is configured
    a_on = (cfg.a_sel != aos_pkg::CM_OFF) | cfg.a_ovd;
    if (a_on) begin
      s_nxt.clamp = cfg.a_ovd | aos_clamp_fn(cfg.a_sel, s_nxt.jd);
    end else begin
      s_nxt.clamp = cfg.b_ovd | aos_clamp_fn({1'b0, cfg.b_sel}, s_nxt.jd);
    end
    rise = s_nxt.jd & ~s_r.jd;
    fall = s_r.jd & ~s_nxt.jd;
    st.jd = s_r.jd;
    st.clamp = s_r.clamp;
    st.evt = '0;
    st.evt[aos_pkg::EV_JD1_R] = rise[0];
    st.evt[aos_pkg::EV_JD1_F] = fall[0];
    st.evt[aos_pkg::EV_JD2_R] = rise[1];
    st.evt[aos_pkg::EV_JD2_F] = fall[1];
    st.evt[aos_pkg::EV_JD3_R] = rise[2];
    st.evt[aos_pkg::EV_JD3_F] = fall[2];
    st.evt[aos_pkg::EV_CLA_R] = a_on & s_nxt.clamp & ~s_r.clamp;
    st.evt[aos_pkg::EV_CLA_F] = a_on & ~s_nxt.clamp & s_r.clamp;
    st.evt[aos_pkg::EV_CLB_R] = ~a_on & s_nxt.clamp & ~s_r.clamp;
    st.evt[aos_pkg::EV_CLB_F] = ~a_on & ~s_nxt.clamp & s_r.clamp;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  jd_follow_a: assert property (@(posedge pclk) disable iff (!presetn)
    1'b1 |=> st.jd == ($past(pins) & $past(cfg.jd_en)))
    else $error("jack state does not follow its pin");
  clamp_fn_a: assert property (@(posedge pclk) disable iff (!presetn)
    (cfg.a_sel == aos_pkg::CM_JD1 && !cfg.a_ovd) |=> st.clamp == $past(pins[0] & cfg.jd_en[0]))
    else $error("clamp status wrong for first-state mode");
  one_clamp_a: assert property (@(posedge pclk) disable iff (!presetn)
    a_on |-> !(st.evt[aos_pkg::EV_CLB_R] || st.evt[aos_pkg::EV_CLB_F]))
    else $error("inactive clamp raised an event");
endmodule : aos_jack_track

// file: rtl/aos_sleep_domain.sv
// Chosen here: the APB slave port.
`timescale 1ns/1ps
module aos_sleep_domain (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [15:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        core_digital_supply,
  input  wire logic        jack_sense_pin_1,
  input  wire logic        jack_sense_pin_2,
  input  wire logic        jack_sense_pin_3,
  output logic             jack_state_1,
  output logic             jack_state_2,
  output logic             jack_state_3,
  output logic             clamp_status,
  output logic             irq,
  output logic             irq_pin_out,
  output logic             irq_pin_oe_n,
  output logic             sleep_active,
  output logic             core_io_en,
  output logic             keeper_en,
  output logic             sleep_bias_out_en,
  output logic             rst_pin_pullup,
  output logic             rst_pin_pulldown
);
  typedef struct packed {
    aos_pkg::aos_pwr_type pwr;
    logic [15:0]          clamp;
    logic [15:0]          ena;
    logic [aos_pkg::EV_N-1:0] stat;
    logic [aos_pkg::EV_N-1:0] mask;
    logic [15:0]          irqcfg;
    logic [15:0]          pulls;
    logic                 pready;
    logic                 pslverr;
    logic [15:0]          prdata;
    logic                 irq;
    logic                 hold;
    logic                 pin;
    logic                 oe_n;
    logic                 io_en;
  } aos_top_type;

  localparam aos_top_type S_RST = '{
    pwr:    aos_pkg::AOS_AWAKE,
    clamp:  aos_pkg::RST_CLAMP,
    ena:    aos_pkg::RST_ENA,
    stat:   '0,
    mask:   aos_pkg::RST_MASK[aos_pkg::EV_N-1:0],
    irqcfg: aos_pkg::RST_IRQC,
    pulls:  aos_pkg::RST_PULLS,
    pready: 1'b0,
    pslverr: 1'b0,
    prdata: '0,
    irq:    1'b0,
    hold:   1'b0,
    pin:    1'b1,
    oe_n:   1'b0,
    io_en:  1'b1
  };

  aos_top_type          s_r;
  aos_top_type          s_nxt;
  aos_pkg::aos_jcfg_type jcfg;
  aos_pkg::aos_jstat_type jst;
  logic                 setup;
  logic                 wr;
  logic                 hit;
  logic                 asleep;
  logic [15:0]          rd;
  logic [15:0]          wdat;
  logic [aos_pkg::EV_N-1:0] clr;
  logic                 pend;

  // configuration seen by the always-on jack logic
  always_comb begin
    jcfg.jd_en = s_r.ena[aos_pkg::JD_EN_LSB +: aos_pkg::JD_N];
    jcfg.a_sel = s_r.clamp[aos_pkg::CL_A_LSB +: 4];
    jcfg.a_ovd = s_r.clamp[aos_pkg::CL_A_OVD];
    jcfg.b_sel = s_r.clamp[aos_pkg::CL_B_LSB +: 3];
    jcfg.b_ovd = s_r.clamp[aos_pkg::CL_B_OVD];
  end

  aos_jack_track u_jack (
    .pclk    (pclk),
    .presetn (presetn),
    .pins    ({jack_sense_pin_3, jack_sense_pin_2, jack_sense_pin_1}),
    .cfg     (jcfg),
    .st      (jst)
  );

  // register read decode; addresses above the 16-bit space are unmapped
  always_comb begin
    hit = 1'b1;
    rd  = '0;
    case (paddr)
      aos_pkg::aos_addr(aos_pkg::IDX_CLAMP):  rd = s_r.clamp;
      aos_pkg::aos_addr(aos_pkg::IDX_ENA):    rd = s_r.ena;
      aos_pkg::aos_addr(aos_pkg::IDX_STAT):   rd[aos_pkg::EV_N-1:0] = s_r.stat;
      aos_pkg::aos_addr(aos_pkg::IDX_MASK):   rd[aos_pkg::EV_N-1:0] = s_r.mask;
      aos_pkg::aos_addr(aos_pkg::IDX_IRQCFG): rd = s_r.irqcfg;
      aos_pkg::aos_addr(aos_pkg::IDX_PULLS):  rd = s_r.pulls;
      default: hit = 1'b0;
    endcase
  end

  always_comb begin
    s_nxt  = s_r;
    asleep = (s_r.pwr == aos_pkg::AOS_SLEEP);
    setup  = psel & ~penable;
    wdat   = pwdata[15:0];
    // one wait-free access phase: answer is registered during setup
    s_nxt.pready  = setup;
    s_nxt.pslverr = setup & (asleep | ~hit);
    s_nxt.prdata  = (setup & ~asleep & hit & ~pwrite) ? rd : '0;
    wr  = psel & penable & s_r.pready & pwrite & ~s_r.pslverr & ~asleep;
    clr = '0;
    if (wr) begin
      case (paddr)
        aos_pkg::aos_addr(aos_pkg::IDX_CLAMP):  s_nxt.clamp = wdat & aos_pkg::WM_CLAMP;
        aos_pkg::aos_addr(aos_pkg::IDX_ENA):    s_nxt.ena = wdat & aos_pkg::WM_ENA;
        aos_pkg::aos_addr(aos_pkg::IDX_STAT):   clr = wdat[aos_pkg::EV_N-1:0];
        aos_pkg::aos_addr(aos_pkg::IDX_MASK):   s_nxt.mask = wdat[aos_pkg::EV_N-1:0];
        aos_pkg::aos_addr(aos_pkg::IDX_IRQCFG): s_nxt.irqcfg = wdat & aos_pkg::WM_IRQCFG;
        aos_pkg::aos_addr(aos_pkg::IDX_PULLS):  s_nxt.pulls = wdat & aos_pkg::WM_PULLS;
        default: clr = '0;
      endcase
    end
    // an event in the clearing cycle survives the write-one-to-clear
    s_nxt.stat = (s_r.stat & ~clr) | jst.evt;
    // sleep follows the supply only; jack activity has no say
    case (s_r.pwr)
      aos_pkg::AOS_AWAKE: begin
        if (!core_digital_supply) begin
          s_nxt.pwr = aos_pkg::AOS_SLEEP;
        end
      end
      aos_pkg::AOS_SLEEP: begin
        if (core_digital_supply) begin
          s_nxt.pwr = aos_pkg::AOS_AWAKE;
        end
      end
      default: s_nxt.pwr = aos_pkg::AOS_AWAKE;
    endcase
    // only jack-derived sources exist, so sleep irq comes from jack pins
    pend = (|(s_nxt.stat & ~s_nxt.mask)) & ~s_nxt.irqcfg[aos_pkg::IRQ_MSK];
    if (s_nxt.pwr == aos_pkg::AOS_AWAKE) begin
      s_nxt.hold = 1'b0;
    end else if (asleep & s_r.irq) begin
      s_nxt.hold = 1'b1;
    end
    s_nxt.irq = pend | s_nxt.hold;
    // polarity 0 means active-low pin, the usual sense for this line
    s_nxt.pin  = s_nxt.irq ? s_nxt.irqcfg[aos_pkg::IRQ_POLARITY] : ~s_nxt.irqcfg[aos_pkg::IRQ_POLARITY];
    s_nxt.oe_n = s_nxt.irqcfg[aos_pkg::IRQ_OD] & ~s_nxt.irq;
    s_nxt.io_en = (s_nxt.pwr == aos_pkg::AOS_AWAKE);
    // config fields are untouched by the sleep transition itself
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= S_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  always_comb begin
    prdata            = {16'h0000, s_r.prdata};
    pready            = s_r.pready;
    pslverr           = s_r.pslverr;
    jack_state_1      = jst.jd[0];
    jack_state_2      = jst.jd[1];
    jack_state_3      = jst.jd[2];
    clamp_status      = jst.clamp;
    irq               = s_r.irq;
    irq_pin_out       = s_r.pin;
    irq_pin_oe_n      = s_r.oe_n;
    sleep_active      = (s_r.pwr == aos_pkg::AOS_SLEEP);
    core_io_en        = s_r.io_en;
    keeper_en         = s_r.io_en;
    sleep_bias_out_en = s_r.ena[aos_pkg::BIAS_EN];
    rst_pin_pullup    = s_r.pulls[aos_pkg::PULL_UP];
    rst_pin_pulldown  = s_r.pulls[aos_pkg::PULL_DN];
  end

  enter_sleep_a: assert property (@(posedge pclk) disable iff (!presetn)
    (s_r.pwr == aos_pkg::AOS_AWAKE && !core_digital_supply) |=> sleep_active)
    else $error("supply loss did not enter sleep");
  no_wake_a: assert property (@(posedge pclk) disable iff (!presetn)
    (sleep_active && !core_digital_supply) |=> sleep_active)
    else $error("woke without core supply");
  keep_cfg_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(sleep_active) |-> ($stable(s_r.clamp) && $stable(s_r.ena) && $stable(s_r.mask)))
    else $error("config changed on sleep entry");
  sleep_noacc_a: assert property (@(posedge pclk) disable iff (!presetn)
    (sleep_active && psel && !penable) |=> (pready && pslverr && prdata == 32'h0000_0000)
      ##1 ($stable(s_r.clamp) && $stable(s_r.irqcfg) && $stable(s_r.pulls)))
    else $error("register access accepted in sleep");
  pads_off_a: assert property (@(posedge pclk) disable iff (!presetn)
    sleep_active |-> (!core_io_en && !keeper_en))
    else $error("non always-on pads active in sleep");
  irq_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    (sleep_active && irq && !core_digital_supply) |=> irq[*3])
    else $error("irq dropped during sleep");
  evt_latch_a: assert property (@(posedge pclk) disable iff (!presetn)
    (jst.evt != '0) |=> ((s_r.stat & $past(jst.evt)) == $past(jst.evt)))
    else $error("event not latched in status");
  w1c_a: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable && pready && pwrite && !pslverr && jst.evt == '0
      && paddr == aos_pkg::aos_addr(aos_pkg::IDX_STAT))
      |=> (s_r.stat & $past(pwdata[aos_pkg::EV_N-1:0])) == '0)
    else $error("write one did not clear status");
  masked_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!sleep_active && (s_r.stat & ~s_r.mask) == '0) |-> !irq)
    else $error("irq without unmasked status");
  pin_level_a: assert property (@(posedge pclk) disable iff (!presetn)
    irq |-> (irq_pin_out == s_r.irqcfg[aos_pkg::IRQ_POLARITY] && !irq_pin_oe_n))
    else $error("irq pin not at asserted level");
endmodule : aos_sleep_domain

// file: verif/aos_host_model.sv
`timescale 1ns/1ps
module aos_host_model #(
  parameter int WAKE_DLY = 4
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic pin_out,
  input  wire logic pin_oe_n,
  input  wire logic pol,
  input  wire logic supply_req,
  input  wire logic auto_wake,
  output logic      supply_on,
  output logic      irq_seen
);
  int cnt;
  // a released line floats to the board pull-up
  assign irq_seen = ((pin_oe_n ? 1'h1 : pin_out) == pol);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      supply_on <= 1'h1;
      cnt       <= 0;
    end else if (supply_req) begin
      supply_on <= 1'h1;
      cnt       <= 0;
    end else if (auto_wake && irq_seen) begin
      // the host services the line, then restores the supply
      cnt <= cnt + 1;
      if (cnt == WAKE_DLY) supply_on <= 1'h1;
    end else begin
      // the supply goes at once; clocks keep running and bus traffic may go on
      supply_on <= 1'h0;
      cnt       <= 0;
    end
  end
endmodule : aos_host_model

// file: verif/tb_aos_sleep_domain.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin miscompares++; $display("Error %s exp %0h got %0h", nm, e, g); end end
module tb_aos_sleep_domain;
  logic        pclk = 1'h0, presetn = 1'h0;
  logic        psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic        pready, pslverr, clamp_status, irq, irq_pin_out, irq_pin_oe_n;
  logic        sleep_active, core_io_en, keeper_en, bias_en, pull_up, pull_dn;
  logic [2:0]  pins = 3'h0, js;
  logic        supply_on, supply_req = 1'h1, auto_wake = 1'h0, pol = 1'h0, host_irq;
  int          miscompares = 0, n_checks = 0;

  always #25 pclk = ~pclk;

  aos_sleep_domain dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .core_digital_supply(supply_on), .jack_sense_pin_1(pins[0]), .jack_sense_pin_2(pins[1]),
    .jack_sense_pin_3(pins[2]), .jack_state_1(js[0]), .jack_state_2(js[1]), .jack_state_3(js[2]),
    .clamp_status(clamp_status), .irq(irq), .irq_pin_out(irq_pin_out), .irq_pin_oe_n(irq_pin_oe_n),
    .sleep_active(sleep_active), .core_io_en(core_io_en), .keeper_en(keeper_en),
    .sleep_bias_out_en(bias_en), .rst_pin_pullup(pull_up), .rst_pin_pulldown(pull_dn));

  aos_host_model #(.WAKE_DLY(4)) host (
    .pclk(pclk), .presetn(presetn), .pin_out(irq_pin_out), .pin_oe_n(irq_pin_oe_n), .pol(pol),
    .supply_req(supply_req), .auto_wake(auto_wake), .supply_on(supply_on), .irq_seen(host_irq));

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : print_verdict

  task automatic apb(input logic w, input logic [15:0] idx, input logic [15:0] wd,
                     output logic [31:0] rd, output logic err);
    int i;
    @(posedge pclk);
    psel <= 1'h1; penable <= 1'h0; pwrite <= w;
    paddr <= {idx[13:0], 2'h0}; pwdata <= {16'h0000, wd};
    @(posedge pclk);
    penable <= 1'h1;
    // look mid-cycle: the registered answer stands there, free of the race at the edge that completes it
    for (i = 0; i < 16; i++) begin
      @(negedge pclk);
      if (pready === 1'h1) break;
      @(posedge pclk);
    end
    if (i == 16) begin miscompares++; print_verdict(); end
    rd = prdata;
    err = pslverr;
    @(posedge pclk);
    psel <= 1'h0; penable <= 1'h0;
  endtask : apb

  task automatic wr(input logic [15:0] idx, input logic [15:0] d);
    logic [31:0] r; logic e;
    apb(1'h1, idx, d, r, e);
    `CHK("write_err", 1'h0, e)
  endtask : wr

  task automatic rdc(input string nm, input logic [15:0] idx, input logic [15:0] x);
    logic [31:0] r; logic e;
    apb(1'h0, idx, 16'h0000, r, e);
    `CHK(nm, {16'h0000, x}, r)
    `CHK("read_err", 1'h0, e)
  endtask : rdc

  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask : wt

  // pin change lands at the next edge, state is settled one edge later
  task automatic setp(input logic [2:0] v);
    @(posedge pclk);
    pins <= v;
    wt(2);
  endtask : setp

  task automatic t_regs();
    logic [15:0] ix [6] = '{aos_pkg::IDX_CLAMP, aos_pkg::IDX_ENA, aos_pkg::IDX_STAT,
                            aos_pkg::IDX_MASK, aos_pkg::IDX_IRQCFG, aos_pkg::IDX_PULLS};
    logic [15:0] rv [6] = '{16'h0000, 16'h0000, 16'h0000, 16'h03FF, 16'h0000, 16'h0001};
    logic [15:0] wm [6] = '{16'h0F1F, 16'h000F, 16'h0000, 16'h03FF, 16'h0007, 16'h0003};
    logic [31:0] r; logic e;
    `CHK("pullup", 1'h1, pull_up)
    `CHK("pulldown", 1'h0, pull_dn)
    for (int i = 0; i < 6; i++) rdc("reset_val", ix[i], rv[i]);
    for (int i = 0; i < 6; i++) if (i != 2) begin
      wr(ix[i], 16'hFFFF);
      rdc("rw_bits", ix[i], wm[i]);
    end
    wt(2);
    `CHK("bias_en", 1'h1, bias_en)
    `CHK("pulldown_set", 1'h1, pull_dn)
    `CHK("irq_masked", 1'h0, irq)
    for (int i = 0; i < 6; i++) if (i != 2) wr(ix[i], rv[i]);
    wr(aos_pkg::IDX_STAT, 16'h03FF);
    rdc("stat_clear", aos_pkg::IDX_STAT, 16'h0000);
    apb(1'h0, 16'h0100, 16'h0000, r, e);
    `CHK("unmapped_err", 1'h1, e)
    `CHK("unmapped_data", 32'h0, r)
    $display("test regs done");
  endtask : t_regs

  task automatic t_jack();
    int rb [3] = '{0, 2, 6};
    setp(3'h1);
    `CHK("jack_disabled", 3'h0, js)
    setp(3'h0);
    wr(aos_pkg::IDX_STAT, 16'h03FF);
    wr(aos_pkg::IDX_ENA, 16'h0007);
    for (int j = 0; j < 3; j++) begin
      setp(3'(1 << j));
      `CHK("jack_follow", 3'(1 << j), js)
      rdc("rise_bit", aos_pkg::IDX_STAT, 16'(1 << rb[j]));
      wr(aos_pkg::IDX_STAT, 16'(1 << rb[j]));
      setp(3'h0);
      rdc("fall_bit", aos_pkg::IDX_STAT, 16'(2 << rb[j]));
      wr(aos_pkg::IDX_STAT, 16'(2 << rb[j]));
    end
    $display("test jack done");
  endtask : t_jack

  task automatic t_clamp();
    logic [15:0] cv [16] = '{16'h0000, 16'h0001, 16'h0002, 16'h0003, 16'h0004, 16'h0005,
                             16'h0006, 16'h0007, 16'h0008, 16'h0009, 16'h0010, 16'h0500,
                             16'h0300, 16'h0800, 16'h0601, 16'h0506};
    logic [15:0] ex = 16'h6D32;
    setp(3'h5);
    for (int c = 0; c < 16; c++) begin
      wr(aos_pkg::IDX_CLAMP, cv[c]);
      wt(2);
      `CHK("clamp_status", ex[c], clamp_status)
    end
    wr(aos_pkg::IDX_CLAMP, 16'h0000);
    setp(3'h0);
    wr(aos_pkg::IDX_STAT, 16'h03FF);
    $display("test clamp done");
  endtask : t_clamp

  task automatic t_irq();
    logic [15:0] cf [2] = '{16'h0002, 16'h0004};
    wr(aos_pkg::IDX_MASK, 16'h03FB);
    for (int k = 0; k < 2; k++) begin
      wr(aos_pkg::IDX_IRQCFG, cf[k]);
      pol <= cf[k][1];
      setp(3'h2);
      `CHK("irq_set", 1'h1, irq)
      `CHK("pad_level", cf[k][1], irq_pin_out)
      `CHK("pad_drive", 1'h0, irq_pin_oe_n)
      `CHK("host_irq", 1'h1, host_irq)
      wr(aos_pkg::IDX_STAT, 16'h0004);
      wt(2);
      `CHK("irq_clear", 1'h0, irq)
      `CHK("pad_release", cf[k][2], irq_pin_oe_n)
      `CHK("host_idle", 1'h0, host_irq)
      setp(3'h0);
      `CHK("masked_fall", 1'h0, irq)
      rdc("fall_latched", aos_pkg::IDX_STAT, 16'h0008);
      wr(aos_pkg::IDX_STAT, 16'h0008);
    end
    wr(aos_pkg::IDX_IRQCFG, 16'h0001);
    pol <= 1'h0;
    setp(3'h2);
    `CHK("line_mask", 1'h0, irq)
    setp(3'h0);
    wr(aos_pkg::IDX_STAT, 16'h03FF);
    wr(aos_pkg::IDX_IRQCFG, 16'h0000);
    $display("test irq done");
  endtask : t_irq

  task automatic t_sleep();
    logic [31:0] r; logic e; int bad = 0, i;
    wr(aos_pkg::IDX_CLAMP, 16'h0001);
    wr(aos_pkg::IDX_PULLS, 16'h0002);
    wr(aos_pkg::IDX_MASK, 16'h03FE);
    // supply goes from here; bus accesses made while asleep must be refused
    @(posedge pclk);
    supply_req <= 1'h0;
    wt(3);
    `CHK("asleep", 1'h1, sleep_active)
    `CHK("core_io", 1'h0, core_io_en)
    `CHK("keepers", 1'h0, keeper_en)
    `CHK("irq_quiet", 1'h0, irq)
    `CHK("pulls_kept", 1'h1, pull_dn)
    apb(1'h0, aos_pkg::IDX_STAT, 16'h0000, r, e);
    `CHK("sleep_rd_err", 1'h1, e)
    `CHK("sleep_rd_data", 32'h0, r)
    apb(1'h1, aos_pkg::IDX_MASK, 16'h0000, r, e);
    `CHK("sleep_wr_err", 1'h1, e)
    setp(3'h1);
    `CHK("jack_asleep", 3'h1, js)
    `CHK("irq_asleep", 1'h1, irq)
    setp(3'h0);
    for (i = 0; i < 20; i++) begin
      wt(1);
      if (irq !== 1'h1 || sleep_active !== 1'h1) bad++;
    end
    `CHK("irq_held", 0, bad)
    @(posedge pclk);
    auto_wake <= 1'h1;
    for (i = 0; i < 40 && sleep_active !== 1'h0; i++) wt(1);
    if (i == 40) begin miscompares++; print_verdict(); end
    supply_req <= 1'h1;
    auto_wake <= 1'h0;
    wt(1);
    `CHK("core_io_back", 1'h1, core_io_en)
    rdc("stat_kept", aos_pkg::IDX_STAT, 16'h0033);
    rdc("mask_kept", aos_pkg::IDX_MASK, 16'h03FE);
    rdc("clamp_kept", aos_pkg::IDX_CLAMP, 16'h0001);
    wr(aos_pkg::IDX_STAT, 16'h03FF);
    wt(2);
    `CHK("irq_after_wake", 1'h0, irq)
    $display("test sleep done");
  endtask : t_sleep

  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'h1;
    wt(1);
    t_regs();
    t_jack();
    t_clamp();
    t_irq();
    t_sleep();
    print_verdict();
  end
endmodule : tb_aos_sleep_domain
